/* verilog/vsl_pkg.sv */
// shared constants, field layouts and coding functions of the video serializer link
package vsl_pkg;
    // clock and rates, in kHz
    localparam int REF_KHZ = 250000; // ref_clk, 4 ns
    localparam int PCLK_MAX_KHZ = 85000;
    localparam int LEG_MAX_KHZ = 65000;
    localparam int LF_EDGE_KHZ = 15000;
    localparam int PCLK_MIN_KHZ = 5000;
    localparam int LOSS_KHZ = 1000;
    localparam int BC_KBPS = 10000; // back channel line rate
    // periods in ref cycles derived from the rates
    localparam int CYC_MAX = REF_KHZ / PCLK_MAX_KHZ;
    localparam int CYC_LEG = REF_KHZ / LEG_MAX_KHZ;
    localparam int CYC_LF = REF_KHZ / LF_EDGE_KHZ;
    localparam int CYC_MIN = REF_KHZ / PCLK_MIN_KHZ;
    localparam int CYC_LOSS = REF_KHZ / LOSS_KHZ;
    localparam int BC_DIV = REF_KHZ / BC_KBPS;
    // symbol layout
    localparam int SYM_W = 35;
    localparam int PAY_W = 34;
    localparam int LEG_W = 28;
    localparam int PIX_W = 24;
    localparam int CTL_W = 4;
    localparam int AUD_W = 3;
    localparam int LFSR_W = 16;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;
    localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hd008;
    // back channel frame: {intLow, gpio, ctl, crc}
    localparam int GPIO_W = 4;
    localparam int BCTL_W = 8;
    localparam int CRC_W = 4;
    localparam int BC_DATA_W = 1 + GPIO_W + BCTL_W;
    localparam int BC_FRM_W = BC_DATA_W + CRC_W;
    localparam int BC_TO_CYC = 2 * BC_FRM_W * BC_DIV;
    // control signal filter
    localparam int FLT_WIN = 130;
    localparam int FLT_MINP = 3;
    localparam int FLT_LIM_DH = 2;
    localparam int FLT_LIM_VS = 1;
    localparam int FAULT_W = 6;
    // register offsets and fields
    localparam logic [7:0] REG_PWR = 8'h01;
    localparam logic [7:0] REG_CFG = 8'h03;
    localparam logic [7:0] REG_LF = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_RGPIO = 8'h1c;
    localparam logic [7:0] REG_RCTL = 8'h1d;
    localparam logic [7:0] REG_INTCFG = 8'hc6;
    localparam logic [7:0] REG_ISR = 8'hc7;
    localparam int PWR_AUTOPD = 7;
    localparam int CFG_EDGE = 0;
    localparam int CFG_COMPAT = 1;
    localparam int CFG_FILT = 2;
    localparam int CFG_SLEEP = 3;
    localparam int INT_EN_HI = 5;
    localparam int INT_EN_LO = 0;
    localparam logic [7:0] CFG_RST = 8'h05; // rising edge, filter on
    localparam logic [1:0] LF_RST = 2'h0;

    // scrambler step
    function automatic logic [LFSR_W-1:0] vsl_lfsr_next(input logic [LFSR_W-1:0] s);
        return {s[LFSR_W-2:0], ^(s & LFSR_TAPS)};
    endfunction

    // scrambler mask across the payload
    function automatic logic [PAY_W-1:0] vsl_mask(input logic [LFSR_W-1:0] s);
        return {s[PAY_W-2*LFSR_W-1:0], s, s};
    endfunction

    // ones count for the balance decision
    function automatic logic [5:0] vsl_ones(input logic [PAY_W-1:0] w);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < PAY_W; i++) begin
            n = n + {5'h00, w[i]};
        end
        return n;
    endfunction

    // bit-fold check of the back channel frame
    function automatic logic [CRC_W-1:0] vsl_crc(input logic [BC_DATA_W-1:0] d);
        logic [CRC_W-1:0] c;
        c = 4'h0;
        for (int i = 0; i < BC_DATA_W; i++) begin
            c[i % CRC_W] = c[i % CRC_W] ^ d[i];
        end
        return c;
    endfunction
endpackage

/* verilog/vsl_link_if.sv */
// link between serializer and deserializer: forward symbols and slow return channel
`timescale 1ns/1ps
`default_nettype none
interface vsl_link_if;
    import vsl_pkg::*;
    logic [SYM_W-1:0] fwdSym; // forward_channel symbol
    logic fwdStb; // one symbol per pixel clock
    logic fwdLegacy; // 28-bit legacy framing
    logic linkOn; // serializer transmitting
    logic backBit; // slow_return_channel data bit
    logic backStb; // one bit per strobe
    logic backFrm; // first bit of a frame
    modport ser (output fwdSym, output fwdStb, output fwdLegacy, output linkOn,
        input backBit, input backStb, input backFrm);
    modport des (input fwdSym, input fwdStb, input fwdLegacy, input linkOn,
        output backBit, output backStb, output backFrm);
endinterface
`default_nettype wire

/* verilog/vsl_deserializer.sv */
// far end: decodes forward symbols and sends the slow return channel
`timescale 1ns/1ps
`default_nettype none
module vsl_deserializer
    import vsl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic power_down_n,
    input wire logic remote_interrupt_in,
    input wire logic [GPIO_W-1:0] gpioIn,
    input wire logic [BCTL_W-1:0] ctlByteIn,
    output logic [PIX_W-1:0] pixOut,
    output logic deOut,
    output logic hsOut,
    output logic vsOut,
    output logic [CTL_W-1:0] ctlOut,
    output logic [AUD_W-1:0] audOut,
    output logic pixStbOut,
    vsl_link_if.des link
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int AS_W = 2 + GPIO_W + BCTL_W;
    logic [AS_W-1:0] as1_r; // first stage, read only by as2_r
    logic [AS_W-1:0] as2_r;
    always_ff @(posedge ref_clk) begin
        as1_r <= {power_down_n, remote_interrupt_in, gpioIn, ctlByteIn};
        as2_r <= as1_r;
    end
    logic pdnS;
    logic intLowS;
    assign pdnS = as2_r[AS_W-1];
    assign intLowS = ~as2_r[AS_W-2]; // pin low means request

    ////////////////////////////////////////////////////////////////////////
    // forward decode
    logic [LFSR_W-1:0] lfsr_r; // mirrors the serializer scrambler
    logic [PAY_W-1:0] pay;
    logic [LEG_W-2:0] leg;
    assign pay = (link.fwdSym[SYM_W-1] ? ~link.fwdSym[PAY_W-1:0] : link.fwdSym[PAY_W-1:0]) ^ vsl_mask(lfsr_r);
    assign leg = link.fwdSym[LEG_W-1] ? ~link.fwdSym[LEG_W-2:0] : link.fwdSym[LEG_W-2:0];

    // scrambler restarts whenever the link drops so both ends realign
    always_ff @(posedge ref_clk) begin
        if (srst || !link.linkOn) begin
            lfsr_r <= LFSR_SEED;
        end else if (link.fwdStb && !link.fwdLegacy) begin
            lfsr_r <= vsl_lfsr_next(lfsr_r);
        end
    end

    // registered video outputs
    always_ff @(posedge ref_clk) begin
        if (srst || !pdnS) begin
            {audOut, ctlOut, vsOut, hsOut, deOut, pixOut} <= '0;
            pixStbOut <= 1'b0;
        end else begin
            pixStbOut <= link.fwdStb && link.linkOn;
            if (link.fwdStb && link.linkOn) begin
                if (link.fwdLegacy) begin
                    {audOut, ctlOut} <= '0; // legacy symbols carry no side bits
                    {vsOut, hsOut, deOut, pixOut} <= leg;
                end else begin
                    {audOut, ctlOut, vsOut, hsOut, deOut, pixOut} <= pay;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // return channel transmitter, silent while powered down
    logic [4:0] div_r;
    logic [4:0] bitIdx_r;
    logic [BC_FRM_W-1:0] frm_r;
    logic [BC_DATA_W-1:0] frmData;
    assign frmData = {intLowS, as2_r[GPIO_W+BCTL_W-1:0]};
    always_ff @(posedge ref_clk) begin
        if (srst || !pdnS) begin
            div_r <= 5'h00;
            bitIdx_r <= 5'h00;
            frm_r <= '0;
            link.backStb <= 1'b0;
            if (srst) link.backBit <= 1'b0; // a powered-down end holds its last bit
            link.backFrm <= 1'b0;
        end else begin
            link.backStb <= 1'b0;
            link.backFrm <= 1'b0;
            if (div_r == 5'(BC_DIV - 1)) begin
                div_r <= 5'h00;
                link.backStb <= 1'b1;
                if (bitIdx_r == 5'h00) begin
                    // snapshot frame with its check bits
                    frm_r <= {frmData, vsl_crc(frmData)} << 1;
                    link.backBit <= frmData[BC_DATA_W-1];
                    link.backFrm <= 1'b1;
                end else begin
                    frm_r <= frm_r << 1;
                    link.backBit <= frm_r[BC_FRM_W-1];
                end
                bitIdx_r <= (bitIdx_r == 5'(BC_FRM_W - 1)) ? 5'h00 : bitIdx_r + 5'h01;
            end else begin
                div_r <= div_r + 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/vsl_serializer.sv */
// serializer end: framing, control signal filter, power, clock watch and interrupt relay
`timescale 1ns/1ps
`default_nettype none
module vsl_serializer
    import vsl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic power_down_n,
    input wire logic pixClk,
    input wire logic [PIX_W-1:0] pixData,
    input wire logic data_enable,
    input wire logic horizontal_sync,
    input wire logic vertical_sync,
    input wire logic [CTL_W-1:0] ctlBits,
    input wire logic [AUD_W-1:0] audioBits,
    input wire logic cfgLowFreq,
    input wire logic cfgBackCompat,
    input wire logic [FAULT_W-1:0] linkFault,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic interrupt_out_n,
    vsl_link_if.ser link
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int AS_W = PIX_W + CTL_W + AUD_W + 3 + 4 + FAULT_W;
    logic [AS_W-1:0] as1_r; // first stage, read only by as2_r
    logic [AS_W-1:0] as2_r;
    logic pclkD_r; // third stage for edge finding
    always_ff @(posedge ref_clk) begin
        as1_r <= {power_down_n, pixClk, cfgLowFreq, cfgBackCompat, linkFault,
            audioBits, ctlBits, vertical_sync, horizontal_sync, data_enable, pixData};
        as2_r <= as1_r;
        pclkD_r <= as2_r[AS_W-2];
    end
    logic pdnS;
    logic pclkS;
    logic lfPin;
    logic compatPin;
    logic [FAULT_W-1:0] faultS;
    logic [PAY_W-1:0] payIn; // {audio, ctl, vs, hs, de, pixel}
    assign {pdnS, pclkS, lfPin, compatPin, faultS} = as2_r[AS_W-1:PAY_W];
    assign payIn = as2_r[PAY_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] cfg_r;
    logic [1:0] lf_r;
    logic autoPd_r;
    logic [1:0] intEn_r; // {hi, lo} enable bits
    logic intN_r; // interrupt_out_n
    logic [GPIO_W-1:0] rGpio_r;
    logic [BCTL_W-1:0] rCtl_r;
    logic lfEff_r; // low frequency mode in force
    logic pclkLost_r;
    logic freqOk_r;
    logic crcErr_r;
    logic remPowered;
    logic lowPower;
    logic compat;
    logic fwReset; // framing reset: bus reset or power-down pin
    assign compat = cfg_r[CFG_COMPAT] | compatPin;
    assign fwReset = srst | ~pdnS;

    // software-written fields; no clock-loss term touches them
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_r <= CFG_RST;
            lf_r <= LF_RST;
            autoPd_r <= 1'b0;
            intEn_r <= 2'h0;
        end else if (regWr) begin
            if (regAddr == REG_CFG) cfg_r <= regWdata;
            if (regAddr == REG_LF) lf_r <= regWdata[1:0];
            if (regAddr == REG_PWR) autoPd_r <= regWdata[PWR_AUTOPD];
            if (regAddr == REG_INTCFG) intEn_r <= {regWdata[INT_EN_HI], regWdata[INT_EN_LO]};
        end
    end

    // new low frequency setting only takes hold at a power-down release
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lfEff_r <= 1'b0;
        end else if (~pdnS) begin
            lfEff_r <= (lf_r != 2'h0) | lfPin;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                REG_PWR: regRdata <= {autoPd_r, 7'h00};
                REG_CFG: regRdata <= cfg_r;
                REG_LF: regRdata <= {6'h00, lf_r};
                REG_STAT: regRdata <= {2'h0, lowPower, crcErr_r, remPowered, freqOk_r, pclkLost_r,
                    ~|faultS};
                REG_RGPIO: regRdata <= {4'h0, rGpio_r};
                REG_RCTL: regRdata <= rCtl_r;
                REG_INTCFG: regRdata <= {2'h0, intEn_r[1], 4'h0, intEn_r[0]};
                REG_ISR: regRdata <= {7'h00, ~intN_r};
                default: regRdata <= 8'h00; // unmapped
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pixel clock edges, loss and range watch
    logic pixStb;
    logic [8:0] perCnt_r; // ref cycles since last rising edge
    assign pixStb = cfg_r[CFG_EDGE] ? (pclkS & ~pclkD_r) : (~pclkS & pclkD_r);
    always_ff @(posedge ref_clk) begin
        if (fwReset) begin
            perCnt_r <= 9'h000;
            pclkLost_r <= 1'b1;
            freqOk_r <= 1'b0;
        end else if (pclkS & ~pclkD_r) begin
            perCnt_r <= 9'h001;
            pclkLost_r <= 1'b0;
            // bands are whole-cycle approximations of the limits
            if (lfEff_r) begin
                freqOk_r <= perCnt_r > 9'(CYC_LF) && perCnt_r <= 9'(CYC_MIN);
            end else begin
                freqOk_r <= perCnt_r >= 9'(compat ? CYC_LEG : CYC_MAX) && perCnt_r <= 9'(CYC_LF);
            end
        end else if (perCnt_r >= 9'(CYC_LOSS)) begin
            pclkLost_r <= 1'b1;
            freqOk_r <= 1'b0;
        end else begin
            perCnt_r <= perCnt_r + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // video control signal filter, index 0 de, 1 hs, 2 vs
    logic [2:0] ctlRaw;
    logic [2:0] ctlOut;
    assign ctlRaw = payIn[PIX_W+2:PIX_W];
    for (genvar g = 0; g < 3; g++) begin : gFilt
        logic prev_r;
        logic out_r;
        logic [7:0] stab_r; // pixel clocks the raw level has held
        logic [7:0] win_r; // pixel clocks into the transition window
        logic [1:0] tr_r; // transitions passed in this window
        logic [7:0] minP;
        logic [1:0] lim;
        assign minP = (g < 2 && cfg_r[CFG_FILT]) ? 8'(FLT_MINP) : 8'h01;
        assign lim = (g == 2) ? 2'(FLT_LIM_VS) : 2'(FLT_LIM_DH);
        assign ctlOut[g] = out_r;
        always_ff @(posedge ref_clk) begin
            if (fwReset) begin
                prev_r <= 1'b0;
                out_r <= 1'b0;
                stab_r <= 8'h00;
                win_r <= 8'h00;
                tr_r <= 2'h0;
            end else if (pixStb) begin
                prev_r <= ctlRaw[g];
                stab_r <= (ctlRaw[g] != prev_r) ? 8'h01 : (stab_r == 8'hff ? stab_r : stab_r + 8'h01);
                if (tr_r != 2'h0) begin
                    win_r <= (win_r == 8'(FLT_WIN - 1)) ? 8'h00 : win_r + 8'h01;
                end
                if (ctlRaw[g] != out_r && (ctlRaw[g] != prev_r ? 8'h01 : stab_r + 8'h01) >= minP
                        && tr_r < lim && win_r != 8'(FLT_WIN - 1)) begin
                    out_r <= ctlRaw[g];
                    tr_r <= tr_r + 2'h1;
                end else if (win_r == 8'(FLT_WIN - 1)) begin
                    tr_r <= 2'h0; // window closes
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // forward framing
    logic [LFSR_W-1:0] lfsr_r;
    logic rdPos_r; // running disparity sign
    logic [PAY_W-1:0] scr;
    logic [PAY_W-1:0] legPay;
    logic [PAY_W-1:0] word;
    logic inv;
    logic linkOn;
    assign linkOn = pdnS & ~lowPower & ~(cfg_r[CFG_SLEEP] & pclkLost_r);
    assign scr = {payIn[PAY_W-1:PIX_W+3], ctlOut, payIn[PIX_W-1:0]} ^ vsl_mask(lfsr_r);
    assign legPay = {7'h00, ctlOut, payIn[PIX_W-1:0]};
    assign word = compat ? legPay : scr;
    assign inv = (vsl_ones(word) > 6'((compat ? LEG_W - 1 : PAY_W) / 2)) == rdPos_r;
    always_ff @(posedge ref_clk) begin
        if (fwReset || !linkOn) begin
            lfsr_r <= LFSR_SEED;
            rdPos_r <= 1'b0;
            link.fwdSym <= '0;
            link.fwdStb <= 1'b0;
            link.fwdLegacy <= 1'b0;
            link.linkOn <= 1'b0;
        end else begin
            link.linkOn <= 1'b1;
            link.fwdStb <= pixStb;
            if (pixStb) begin
                link.fwdLegacy <= compat;
                rdPos_r <= rdPos_r ^ (vsl_ones(word) != 6'((compat ? LEG_W - 1 : PAY_W) / 2) && !inv);
                if (compat) begin
                    link.fwdSym <= {7'h00, inv, inv ? ~legPay[LEG_W-2:0] : legPay[LEG_W-2:0]};
                end else begin
                    lfsr_r <= vsl_lfsr_next(lfsr_r);
                    link.fwdSym <= {inv, inv ? ~scr : scr};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // return channel receiver and far-end power watch
    logic [BC_FRM_W-2:0] bsh_r;
    logic [4:0] bIdx_r;
    logic [10:0] toCnt_r; // cycles since last good frame
    logic remIntLow_r;
    logic intEdge;
    logic [BC_FRM_W-1:0] frm;
    assign frm = {bsh_r, link.backBit};
    assign remPowered = toCnt_r < 11'(BC_TO_CYC);
    assign lowPower = autoPd_r & ~remPowered;
    assign intEdge = link.backStb && bIdx_r == 5'(BC_FRM_W - 1)
        && frm[CRC_W-1:0] == vsl_crc(frm[BC_FRM_W-1:CRC_W]) && frm[BC_FRM_W-1] && !remIntLow_r;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bsh_r <= '0;
            bIdx_r <= 5'h00;
            toCnt_r <= 11'(BC_TO_CYC);
            remIntLow_r <= 1'b0;
            rGpio_r <= '0;
            rCtl_r <= '0;
            crcErr_r <= 1'b0;
        end else begin
            if (toCnt_r < 11'(BC_TO_CYC)) toCnt_r <= toCnt_r + 11'h001;
            if (link.backStb) begin
                bsh_r <= frm[BC_FRM_W-2:0];
                bIdx_r <= link.backFrm ? 5'h01 : (bIdx_r == 5'(BC_FRM_W - 1) ? 5'h00 : bIdx_r + 5'h01);
                if (!link.backFrm && bIdx_r == 5'(BC_FRM_W - 1)) begin
                    if (frm[CRC_W-1:0] == vsl_crc(frm[BC_FRM_W-1:CRC_W])) begin
                        toCnt_r <= 11'h000;
                        crcErr_r <= 1'b0;
                        {remIntLow_r, rGpio_r, rCtl_r} <= frm[BC_FRM_W-1:CRC_W];
                    end else begin
                        crcErr_r <= 1'b1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt relay: new remote request sets, status read clears, set wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            intN_r <= 1'b1;
        end else if (intEdge && intEn_r == 2'h3) begin
            intN_r <= 1'b0;
        end else if (regRd && regAddr == REG_ISR) begin
            intN_r <= 1'b1;
        end
    end
    assign interrupt_out_n = intN_r;
endmodule
`default_nettype wire

/* testbench/vsl_link_properties.sv */
// link checker: forward symbol and return channel properties
`timescale 1ns/1ps
`default_nettype none
module vsl_link_properties
    import vsl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [SYM_W-1:0] fwdSym,
    input wire logic fwdStb,
    input wire logic fwdLegacy,
    input wire logic linkOn,
    input wire logic backBit,
    input wire logic backStb,
    input wire logic backFrm
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [5:0] gap_r; // cycles since last return bit, saturating
    logic [4:0] bits_r; // return bits seen in this frame
    ////////////////////////////////////////////////////////////
    // gap saturates so a paused far end never fakes a short gap
    always_ff @(posedge ref_clk) begin
        if (srst) gap_r <= 6'h3f;
        else if (backStb) gap_r <= 6'h00;
        else if (gap_r != 6'h3f) gap_r <= gap_r + 6'h01;
    end
    // frame bit counter, restarted by the frame mark
    always_ff @(posedge ref_clk) begin
        if (srst) bits_r <= 5'h00;
        else if (backFrm) bits_r <= 5'h01;
        else if (backStb && bits_r != 5'h1f) bits_r <= bits_r + 5'h01;
    end
    ////////////////////////////////////////////////////////////
    sequence s_quiet2;
        !fwdStb [*2];
    endsequence
    a_sym_rate: assert property (fwdStb |=> s_quiet2) else $error("symbols too close");
    a_sym_hold: assert property (!fwdStb && linkOn && $past(linkOn) |-> $stable(fwdSym))
        else $error("symbol changed between strobes");
    a_legacy_pad: assert property (fwdStb && fwdLegacy |-> fwdSym[SYM_W-1:LEG_W] == '0)
        else $error("legacy symbol upper bits set");
    a_quiet_off: assert property (!linkOn && !$past(linkOn) |-> !fwdStb) else $error("symbol while off");
    a_bit_spacing: assert property (backStb && gap_r != 6'h3f |-> gap_r == 6'h18)
        else $error("return bit spacing wrong");
    a_frame_mark: assert property (backFrm |-> backStb) else $error("frame mark without bit");
    a_frame_len: assert property (backStb && !backFrm |-> bits_r < 5'h11) else $error("frame too long");
    a_bit_steady: assert property (!backStb |-> $stable(backBit)) else $error("return bit moved");
    c_legacy: cover property (fwdStb && fwdLegacy);
endmodule
`default_nettype wire

/* testbench/video_serializer_link_control_tb.sv */
// testbench: serializer and deserializer joined over the link
`timescale 1ns/1ps
`default_nettype none
module video_serializer_link_control_tb;
    import vsl_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, serPd_n = 1'b1, desPd_n = 1'b1, pixClk = 1'b0, pixRun = 1'b1;
    logic de = 1'b0, hs = 1'b0, vs = 1'b0, compat = 1'b0, lowFreq = 1'b0, remInt = 1'b1;
    logic regWr = 1'b0, regRd = 1'b0, intOut_n, deOut, hsOut, vsOut;
    logic [PIX_W-1:0] pix = 24'h0, pixOut;
    logic [CTL_W-1:0] ctl = 4'h0, ctlOut;
    logic [AUD_W-1:0] aud = 3'h0, audOut;
    logic [FAULT_W-1:0] fault = 6'h00;
    logic [GPIO_W-1:0] gpio = 4'h0;
    logic [7:0] ctlByte = 8'h00, regAddr = 8'h00, regWdata = 8'h00, regRdata;
    logic [31:0] rdv, seed = 32'h7e9a;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    vsl_link_if link();
    vsl_serializer i_vsl_serializer (.ref_clk(ref_clk), .srst(srst), .power_down_n(serPd_n), .pixClk(pixClk),
        .pixData(pix), .data_enable(de), .horizontal_sync(hs), .vertical_sync(vs), .ctlBits(ctl),
        .audioBits(aud), .cfgLowFreq(lowFreq), .cfgBackCompat(compat), .linkFault(fault), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .interrupt_out_n(intOut_n),
        .link(link));
    vsl_deserializer i_vsl_deserializer (.ref_clk(ref_clk), .srst(srst), .power_down_n(desPd_n),
        .remote_interrupt_in(remInt), .gpioIn(gpio), .ctlByteIn(ctlByte), .pixOut(pixOut), .deOut(deOut),
        .hsOut(hsOut), .vsOut(vsOut), .ctlOut(ctlOut), .audOut(audOut), .pixStbOut(), .link(link));
    vsl_link_properties i_props (.ref_clk(ref_clk), .srst(srst), .fwdSym(link.fwdSym), .fwdStb(link.fwdStb),
        .fwdLegacy(link.fwdLegacy), .linkOn(link.linkOn), .backBit(link.backBit), .backStb(link.backStb),
        .backFrm(link.backFrm));
    ////////////////////////////////////////////////////////////
    always #2 ref_clk = ~ref_clk;
    // 80 ns pixel clock, phase offset from ref_clk; stops low while paused
    initial begin
        #1.3;
        forever #40 pixClk = ~pixClk & pixRun;
    end
    // hang guard, well above the expected run length
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(posedge ref_clk);
        d = {24'h0, regRdata};
    endtask
    // bounded search for hsOut high (k 0) or the interrupt low (k 1)
    task automatic hunt(input int k, input int n);
        logic hit;
        hit = 1'b0;
        repeat (n) begin
            @(posedge ref_clk);
            hit = hit | ((k == 0) ? hsOut : !intOut_n);
        end
        chk({31'h0, hit}, 32'h1);
    endtask
    function automatic logic [31:0] linkBit(input logic [FAULT_W-1:0] f);
        return {31'h0, ~|f};
    endfunction
    task automatic end_of_test();
        if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        waitc(12);
        srst <= 1'b0;
        waitc(400);
        rd(REG_CFG, rdv);
        chk(rdv, {24'h0, CFG_RST});
        rd(8'h55, rdv);
        chk(rdv, 32'h0);
        // each fault kind alone, then a sound cable
        for (int i = 0; i < 7; i++) begin
            fault <= (i == 6) ? 6'h00 : 6'h01 << i;
            waitc(4);
            rd(REG_STAT, rdv);
            chk(rdv & 32'h1, linkBit(fault));
        end
        // random payload, legacy from pin then register
        for (int i = 0; i < 4; i++) begin
            pix <= 24'($random(seed));
            ctl <= 4'($random(seed));
            aud <= 3'($random(seed));
            compat <= (i == 1);
            if (i >= 2) wr(REG_CFG, (i == 2) ? CFG_RST | 8'h02 : 8'h04);
            waitc(200);
            chk({8'h0, pixOut}, {8'h0, pix});
            chk({31'h0, link.fwdLegacy}, {31'h0, i == 1 || i == 2});
            if (i == 0) chk({25'h0, ctlOut, audOut}, {25'h0, ctl, aud});
        end
        rd(REG_STAT, rdv);
        chk(rdv & 32'h4, 32'h0);
        serPd_n <= 1'b0;
        lowFreq <= 1'b1;
        waitc(20);
        chk({31'h0, link.linkOn}, 32'h0);
        serPd_n <= 1'b1;
        waitc(400);
        chk({31'h0, link.linkOn}, 32'h1);
        rd(REG_STAT, rdv);
        chk(rdv & 32'h4, 32'h4);
        // one-pixel glitch with the filter on, then a held level
        de <= 1'b1;
        waitc(20);
        de <= 1'b0;
        waitc(200);
        chk({31'h0, deOut}, 32'h0);
        de <= 1'b1;
        waitc(200);
        chk({31'h0, deOut}, 32'h1);
        wr(REG_CFG, 8'h01);
        hs <= 1'b1;
        waitc(20);
        hs <= 1'b0;
        hunt(0, 300);
        hs <= 1'b1;
        waitc(200);
        chk({31'h0, hsOut}, 32'h0);
        waitc(2800);
        chk({31'h0, hsOut}, 32'h1);
        vs <= 1'b1;
        waitc(200);
        vs <= 1'b0;
        waitc(400);
        chk({31'h0, vsOut}, 32'h1);
        waitc(2600);
        chk({31'h0, vsOut}, 32'h0);
        // interrupt relay and far-end readback
        gpio <= 4'($random(seed));
        ctlByte <= 8'($random(seed));
        wr(REG_INTCFG, 8'h21);
        remInt <= 1'b0;
        hunt(1, 1500);
        rd(REG_ISR, rdv);
        chk(rdv & 32'h1, 32'h1);
        waitc(900);
        chk({31'h0, intOut_n}, 32'h1);
        remInt <= 1'b1;
        waitc(900);
        remInt <= 1'b0;
        hunt(1, 1500);
        rd(REG_ISR, rdv);
        rd(REG_RGPIO, rdv);
        chk(rdv, {28'h0, gpio});
        rd(REG_RCTL, rdv);
        chk(rdv, {24'h0, ctlByte});
        // far end powered down, then back
        wr(REG_PWR, 8'h80);
        desPd_n <= 1'b0;
        waitc(1200);
        chk({31'h0, link.linkOn}, 32'h0);
        rd(REG_STAT, rdv);
        chk(rdv & 32'h20, 32'h20);
        desPd_n <= 1'b1;
        waitc(1200);
        chk({31'h0, link.linkOn}, 32'h1);
        // pixel clock lost and found, settings kept
        wr(REG_CFG, 8'h09);
        pixRun <= 1'b0;
        waitc(400);
        chk({31'h0, link.linkOn}, 32'h0);
        rd(REG_STAT, rdv);
        chk(rdv & 32'h2, 32'h2);
        rd(REG_CFG, rdv);
        chk(rdv, 32'h9);
        pixRun <= 1'b1;
        waitc(400);
        chk({31'h0, link.linkOn}, 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
